// ==== rtl/instruction_timing_decoder.sv ====
`timescale 1ns/1ps
`include "itd_regs.svh"

module instruction_timing_decoder #(
    parameter int MAX_EXTRA = 2
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic decode_valid,
    input wire logic [7:0] opcode,
    input wire logic [7:0] operand1,
    input wire logic [7:0] operand2,
    input wire logic [15:0] instr_addr,
    input wire logic branch_taken,
    input wire logic [1:0] flash_read_timing,
    input wire logic [1:0] bank_select,
    input wire logic sfr_write,
    input wire logic sfr_read,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic [1:0] instr_bytes,
    output logic [3:0] instr_cycles,
    output logic decode_done,
    output logic busy,
    output logic [15:0] branch_target,
    output logic target_valid,
    output logic [7:0] bank_reg_addr,
    output logic [7:0] indirect_reg_addr,
    output logic direct_is_sfr,
    output logic [15:0] data_pointer,
    output logic nop_like
);

    initial begin
        if (MAX_EXTRA < 0 || MAX_EXTRA > 2) begin
            $error("MAX_EXTRA must be 0..2");
        end
    end

    // ------------------------------------------------------------
    // decode functions
    // ------------------------------------------------------------
    function automatic logic [1:0] length_of(input logic [7:0] op);
        logic [1:0] len;
        len = 2'd1;
        if (op == 8'h02 || op == 8'h12 || op == 8'h90) begin
            len = 2'd3;
        end else if (op[4:0] == 5'h01 || op[4:0] == 5'h11) begin
            len = 2'd2;
        end else if (op == 8'h85 || op == 8'h75 || op[3:0] == 4'h3 &&
                     op[7:4] >= 4'h4 && op[7:4] <= 4'h6 ||
                     op == 8'h10 || op == 8'h20 || op == 8'h30 ||
                     op == 8'hd5 || op[7:4] == 4'hb && op[3:0] >= 4'h4) begin
            len = 2'd3;
        end else if (op == 8'h40 || op == 8'h50 || op == 8'h60 ||
                     op == 8'h70 || op == 8'h80 || op[7:3] == 5'b11011 ||
                     op == 8'hc0 || op == 8'hd0 || op == 8'h05 ||
                     op == 8'h15 || op[3:0] == 4'h2 && op[7:4] >= 4'h4 &&
                     op[7:4] <= 4'hd || op[3:0] == 4'h4 &&
                     op[7:4] >= 4'h4 && op[7:4] <= 4'h7 ||
                     op[3:0] == 4'h5 && op[7:4] >= 4'h4 ||
                     op[3:0] == 4'h6 && op[7:4] == 4'h7 ||
                     op[3:0] == 4'h7 && op[7:4] == 4'h7 ||
                     op[7:3] == 5'b01111 || op[7:3] == 5'b10101 ||
                     op[7:1] == 7'b1010011 || op[7:1] == 7'b1000011 ||
                     op[7:3] == 5'b10001 || op[7:1] == 7'b1000011 ||
                     op == 8'ha0 || op == 8'hb0 || op == 8'hb2) begin
            len = 2'd2;
        end
        if (op == `SPARE_OPCODE || op == 8'he5 && 1'b0) begin
            len = 2'd1;
        end
        if (op == 8'he5 || op == 8'hf5 || op == 8'hc5) begin
            len = 2'd2;
        end
        return len;
    endfunction

    // base cycles; ranged ones add alignment and read-timing extra
    function automatic logic [3:0] base_cycles(input logic [7:0] op,
                                               input logic taken);
        logic [3:0] c;
        c = {2'b00, length_of(op)};
        if (op == `SPARE_OPCODE || op == `NOP_OPCODE) begin
            c = 4'd1;
        end else if (op == 8'hf4) begin
            c = 4'd2;
        end else if (op[7:1] == 7'b1110011 || op[7:1] == 7'b1111011 ||
                     op[7:1] == 7'b1100011 || op[7:1] == 7'b1101011 ||
                     op[7:1] == 7'b1000011 && op[0] == 1'b0 && 1'b0) begin
            c = 4'd2;
        end else if (op == 8'h93) begin
            c = 4'd4;
        end else if (op == 8'h83 || op[7:1] == 7'b1110001 ||
                     op[7:1] == 7'b1111001 || op == 8'he0 || op == 8'hf0) begin
            c = 4'd3;
        end else if (op[4:0] == 5'h01 || op[4:0] == 5'h11 || op == 8'h80) begin
            c = 4'd4;
        end else if (op == 8'h02 || op == 8'h12) begin
            c = 4'd5;
        end else if (op == 8'h22 || op == 8'h32) begin
            c = 4'd6;
        end else if (op == 8'h73) begin
            c = 4'd3;
        end else if (op == 8'h40 || op == 8'h50 || op == 8'h60 ||
                     op == 8'h70 || op[7:3] == 5'b11011) begin
            c = taken ? 4'd4 : 4'd2;
        end else if (op == 8'h10 || op == 8'h20 || op == 8'h30 ||
                     op == 8'hd5 || op[7:3] == 5'b10111) begin
            c = taken ? 4'd5 : 4'd3;
        end else if (op == 8'hb5 || op[7:1] == 7'b1011011) begin
            c = taken ? 4'd6 : 4'd4;
        end else if (op == 8'hb4) begin
            c = taken ? 4'd6 : 4'd3;
        end
        return c;
    endfunction

    function automatic logic is_ranged(input logic [7:0] op,
                                       input logic taken);
        logic r;
        r = op == 8'h93 || op[4:0] == 5'h01 || op[4:0] == 5'h11 ||
            op == 8'h80 || op == 8'h02 || op == 8'h12 || op == 8'h22 ||
            op == 8'h32 || op == 8'h73;
        r = r || taken && (op == 8'h40 || op == 8'h50 || op == 8'h60 ||
            op == 8'h70 || op[7:3] == 5'b11011 || op == 8'h10 ||
            op == 8'h20 || op == 8'h30 || op == 8'hd5 || op[7:4] == 4'hb &&
            op[3:0] >= 4'h4);
        return r;
    endfunction

    // ------------------------------------------------------------
    // decode and timing
    // ------------------------------------------------------------
    itd_pkg::dec_state_t state, next_state;
    logic [3:0] count, next_count;
    logic [1:0] next_bytes;
    logic [3:0] next_cycles;
    logic [15:0] next_target;
    logic next_target_valid;
    logic [7:0] next_bank_addr, next_ind_addr;
    logic next_is_sfr, next_nop;
    logic [15:0] next_addr;
    logic [1:0] extra;
    logic taken_op;
    itd_pkg::target_kind_t kind;

    always_comb begin
        next_state = state;
        next_count = count;
        next_bytes = instr_bytes;
        next_cycles = instr_cycles;
        next_target = branch_target;
        next_target_valid = 1'b0;
        next_bank_addr = bank_reg_addr;
        next_ind_addr = indirect_reg_addr;
        next_is_sfr = direct_is_sfr;
        next_nop = nop_like;
        next_addr = 16'h0000;
        extra = 2'd0;
        taken_op = 1'b0;
        kind = itd_pkg::OP_NONE;
        case (state)
            itd_pkg::ST_IDLE: begin
                if (decode_valid) begin
                    taken_op = branch_taken;
                    next_bytes = length_of(opcode);
                    next_addr = instr_addr + {14'h0000, length_of(opcode)};
                    // fixed function: misalignment adds one, slow reads add
                    // more; same placement, read timing and branch outcome always give same timing
                    if (is_ranged(opcode, taken_op)) begin
                        extra = 2'(instr_addr[0]) + (flash_read_timing != 2'd0
                                ? 2'd1 : 2'd0);
                        if (extra > 2'(MAX_EXTRA)) begin
                            extra = 2'(MAX_EXTRA);
                        end
                    end
                    next_cycles = base_cycles(opcode, taken_op)
                                  + {2'b00, extra};
                    if (opcode == 8'h93) begin
                        next_cycles = base_cycles(opcode, taken_op)
                            + {2'b00, extra}
                            + {3'b000, flash_read_timing[1]};
                    end
                    next_nop = opcode == `SPARE_OPCODE ||
                               opcode == `NOP_OPCODE;
                    next_bank_addr = {3'b000, bank_select, opcode[2:0]};
                    next_ind_addr = {3'b000, bank_select, 2'b00,
                                     opcode[0]};
                    next_is_sfr = operand1[`DIRECT_SFR_BIT];
                    if (opcode[4:0] == 5'h01 || opcode[4:0] == 5'h11) begin
                        kind = itd_pkg::OP_PAGE;
                    end else if (opcode == 8'h02 || opcode == 8'h12) begin
                        kind = itd_pkg::OP_LONG;
                    end else if (length_of(opcode) == 2'd2 &&
                                 (opcode == 8'h80 || opcode == 8'h40 ||
                                  opcode == 8'h50 || opcode == 8'h60 ||
                                  opcode == 8'h70 ||
                                  opcode[7:3] == 5'b11011)) begin
                        kind = itd_pkg::OP_REL;
                    end else if (length_of(opcode) == 2'd3 &&
                                 opcode != 8'h90 && opcode != 8'h85 &&
                                 opcode != 8'h75 && opcode[3:0] != 4'h3) begin
                        kind = itd_pkg::OP_DIRECT;
                    end
                    case (kind)
                        itd_pkg::OP_REL: begin
                            next_target = next_addr
                                + {{8{operand1[7]}}, operand1};
                            next_target_valid = 1'b1;
                        end
                        itd_pkg::OP_DIRECT: begin
                            next_target = next_addr
                                + {{8{operand2[7]}}, operand2};
                            next_target_valid = 1'b1;
                        end
                        itd_pkg::OP_PAGE: begin
                            next_target = {next_addr[15:11], opcode[7:5],
                                           operand1};
                            next_target_valid = 1'b1;
                        end
                        itd_pkg::OP_LONG: begin
                            next_target = {operand1, operand2};
                            next_target_valid = 1'b1;
                        end
                        default: begin
                            next_target = branch_target;
                        end
                    endcase
                    next_count = next_cycles - 4'd1;
                    if (next_cycles > 4'd1) begin
                        next_state = itd_pkg::ST_WAIT;
                    end
                end
            end
            itd_pkg::ST_WAIT: begin
                next_count = count - 4'd1;
                if (count == 4'd1) begin
                    next_state = itd_pkg::ST_IDLE;
                end
            end
            default: begin
                next_state = itd_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state <= itd_pkg::ST_IDLE;
            count <= 4'd0;
            instr_bytes <= 2'd0;
            instr_cycles <= 4'd0;
            branch_target <= 16'h0000;
            target_valid <= 1'b0;
            bank_reg_addr <= 8'h00;
            indirect_reg_addr <= 8'h00;
            direct_is_sfr <= 1'b0;
            nop_like <= 1'b0;
            decode_done <= 1'b0;
            busy <= 1'b0;
        end else if (clk_en) begin
            state <= next_state;
            count <= next_count;
            instr_bytes <= next_bytes;
            instr_cycles <= next_cycles;
            branch_target <= next_target;
            target_valid <= next_target_valid;
            bank_reg_addr <= next_bank_addr;
            indirect_reg_addr <= next_ind_addr;
            direct_is_sfr <= next_is_sfr;
            nop_like <= next_nop;
            decode_done <= state == itd_pkg::ST_IDLE && decode_valid;
            busy <= next_state == itd_pkg::ST_WAIT;
        end
    end

    // ------------------------------------------------------------
    // data pointer registers
    // ------------------------------------------------------------
    logic [7:0] pointer_low_byte, pointer_high_byte;
    logic [7:0] next_low, next_high, next_rdata;

    always_comb begin
        next_low = pointer_low_byte;
        next_high = pointer_high_byte;
        next_rdata = 8'h00;
        if (sfr_write && sfr_addr == `SFR_POINTER_LOW_BYTE) begin
            next_low = sfr_wdata;
        end else if (sfr_write && sfr_addr == `SFR_POINTER_HIGH_BYTE) begin
            next_high = sfr_wdata;
        end
        if (sfr_read && sfr_addr == `SFR_POINTER_LOW_BYTE) begin
            next_rdata = pointer_low_byte;
        end else if (sfr_read && sfr_addr == `SFR_POINTER_HIGH_BYTE) begin
            next_rdata = pointer_high_byte;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pointer_low_byte <= `POINTER_LOW_BYTE_RESET;
            pointer_high_byte <= `POINTER_HIGH_BYTE_RESET;
            sfr_rdata <= 8'h00;
            data_pointer <= 16'h0000;
        end else if (clk_en) begin
            pointer_low_byte <= next_low;
            pointer_high_byte <= next_high;
            sfr_rdata <= next_rdata;
            data_pointer <= {next_high, next_low};
        end
    end

endmodule // instruction_timing_decoder

// ==== inc/itd_regs.svh ====
`ifndef ITD_REGS_SVH
`define ITD_REGS_SVH
// special-function addresses, reset values and decode constants
`define SFR_POINTER_LOW_BYTE 8'h82
`define SFR_POINTER_HIGH_BYTE 8'h83
`define POINTER_LOW_BYTE_RESET 8'h00
`define POINTER_HIGH_BYTE_RESET 8'h00
`define DIRECT_SFR_BIT 7
`define SPARE_OPCODE 8'ha5
`define NOP_OPCODE 8'h00
`define BANK_SELECT_LSB 3
`endif

// ==== inc/itd_pkg.sv ====
package itd_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01
    } dec_state_t;
    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_REL = 3'b001,
        OP_PAGE = 3'b010,
        OP_LONG = 3'b011,
        OP_DIRECT = 3'b100
    } target_kind_t;
endpackage

// ==== sim/itd_asserts.sv ====
`timescale 1ns/1ps
`include "itd_regs.svh"
// ----------------------------------------
// decoder port checker
// ----------------------------------------
module itd_checker #(
    parameter int MAX_EXTRA = 2
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic decode_valid,
    input wire logic [7:0] opcode,
    input wire logic [7:0] operand1,
    input wire logic [1:0] bank_select,
    input wire logic sfr_write,
    input wire logic sfr_read,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic [1:0] instr_bytes,
    input wire logic [3:0] instr_cycles,
    input wire logic decode_done,
    input wire logic busy,
    input wire logic target_valid,
    input wire logic [7:0] bank_reg_addr,
    input wire logic direct_is_sfr,
    input wire logic [15:0] data_pointer,
    input wire logic nop_like
);
    logic [7:0] cap_op, cap_op1, next_cap_op, next_cap_op1;
    logic [1:0] cap_bank, next_cap_bank;
    logic [3:0] busy_cnt, next_busy_cnt;
    logic take;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    assign take = clk_en && decode_valid && !busy;
    // keep the accepted bytes: the ports may move on before the answer
    always_comb begin
        next_cap_op = take ? opcode : cap_op;
        next_cap_op1 = take ? operand1 : cap_op1;
        next_cap_bank = take ? bank_select : cap_bank;
        next_busy_cnt = busy_cnt;
        if (clk_en && decode_done) begin
            next_busy_cnt = {3'h0, busy};
        end else if (clk_en && busy) begin
            next_busy_cnt = busy_cnt + 4'h1;
        end
    end
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cap_op <= 8'h00;
            cap_op1 <= 8'h00;
            cap_bank <= 2'h0;
            busy_cnt <= 4'h0;
        end else begin
            cap_op <= next_cap_op;
            cap_op1 <= next_cap_op1;
            cap_bank <= next_cap_bank;
            busy_cnt <= next_busy_cnt;
        end
    end
    sequence s_accept;
        clk_en && decode_valid && !busy;
    endsequence
    sequence s_answer;
        decode_done ##0 instr_bytes != 2'h0;
    endsequence
    accept_answer_a: assert property (s_accept |=> s_answer)
        else $error("decode not answered one cycle after acceptance");
    busy_span_a: assert property ($fell(busy) |-> busy_cnt == instr_cycles - 4'h1)
        else $error("busy length differs from cycle count");
    busy_refuse_a: assert property (busy && clk_en |=> !decode_done)
        else $error("request taken while busy");
    cycles_cap_a: assert property (decode_done |-> instr_cycles inside {[4'h1:4'h8]})
        else $error("cycle count outside one to eight");
    nop_decode_a: assert property (decode_done |-> nop_like == (cap_op == `NOP_OPCODE || cap_op == `SPARE_OPCODE))
        else $error("spare or no-op opcode misclassified");
    nop_timing_a: assert property (decode_done && nop_like |-> instr_bytes == 2'h1 && instr_cycles == 4'h1)
        else $error("no-op timing wrong");
    bank_map_a: assert property (decode_done |-> bank_reg_addr == {3'h0, cap_bank, cap_op[2:0]})
        else $error("bank register address wrong");
    direct_space_a: assert property (decode_done |-> direct_is_sfr == cap_op1[7])
        else $error("direct space selection wrong");
    target_done_a: assert property (target_valid |-> decode_done)
        else $error("target flagged without decode");
    low_write_a: assert property (sfr_write && clk_en && sfr_addr == `SFR_POINTER_LOW_BYTE |=> data_pointer[7:0] == $past(sfr_wdata))
        else $error("pointer low byte write lost");
    high_write_a: assert property (sfr_write && clk_en && sfr_addr == `SFR_POINTER_HIGH_BYTE |=> data_pointer[15:8] == $past(sfr_wdata))
        else $error("pointer high byte write lost");
    low_read_a: assert property (sfr_read && !sfr_write && clk_en && sfr_addr == `SFR_POINTER_LOW_BYTE |=> sfr_rdata == data_pointer[7:0])
        else $error("pointer low byte read wrong");
endmodule // itd_checker

bind instruction_timing_decoder itd_checker #(.MAX_EXTRA(MAX_EXTRA)) u_chk (.*);

// ==== sim/code_mem_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// program memory feeding the decoder
// ----------------------------------------
module code_mem_model (
    input wire logic [15:0] fetch_addr,
    output logic [7:0] opcode,
    output logic [7:0] operand1,
    output logic [7:0] operand2
);
    logic [7:0] mem [0:65535];
    // unwritten bytes read as erased flash, never as a stale value
    initial begin
        foreach (mem[i]) mem[i] = 8'hff;
    end
    assign opcode = mem[fetch_addr];
    assign operand1 = mem[fetch_addr + 16'h0001];
    assign operand2 = mem[fetch_addr + 16'h0002];
endmodule // code_mem_model

// ==== sim/test_instruction_timing_decoder.sv ====
`timescale 1ns/1ps
module test_instruction_timing_decoder;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1;
    logic decode_valid = 1'b0;
    logic branch_taken = 1'b0;
    logic sfr_write = 1'b0;
    logic sfr_read = 1'b0;
    logic [15:0] instr_addr = 16'h0000;
    logic [1:0] flash_read_timing = 2'h0;
    logic [1:0] bank_select = 2'h0;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] opcode, operand1, operand2, sfr_rdata;
    logic [7:0] bank_reg_addr, indirect_reg_addr;
    logic [1:0] instr_bytes;
    logic [3:0] instr_cycles;
    logic [15:0] branch_target, data_pointer;
    logic decode_done, busy, target_valid, direct_is_sfr, nop_like;
    int n_mismatch = 0;
    int total_checks = 0;
    always #10 core_clk = ~core_clk;
    code_mem_model u_mem (.fetch_addr(instr_addr), .opcode(opcode),
        .operand1(operand1), .operand2(operand2));
    instruction_timing_decoder #(.MAX_EXTRA(2)) u_dut (.*);
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // waits for idle first: a request while busy would be dropped
    task automatic dec(input logic [15:0] a, input logic [7:0] b0, b1, b2,
            input logic tk, input logic [1:0] nb, input logic [3:0] nc);
        int i;
        for (i = 0; i < 20 && busy !== 1'b0; i++) @(negedge core_clk);
        if (i == 20) begin
            n_mismatch++;
            report_and_stop;
        end
        @(posedge core_clk);
        u_mem.mem[a] <= b0;
        u_mem.mem[a + 16'h0001] <= b1;
        u_mem.mem[a + 16'h0002] <= b2;
        instr_addr <= a;
        branch_taken <= tk;
        decode_valid <= 1'b1;
        @(posedge core_clk);
        decode_valid <= 1'b0;
        @(negedge core_clk);
        check("done", decode_done, 1'b1);
        check("bytes", instr_bytes, nb);
        check("cycles", instr_cycles, nc);
        check("busy", busy, nc > 4'h1);
    endtask
    task automatic run(input logic [7:0] q[$], input logic tk,
            input logic [1:0] nb, input logic [3:0] nc);
        foreach (q[i]) dec(16'h0100, q[i], 8'h10, 8'h20, tk, nb, nc);
    endtask
    task automatic tgt(input logic [15:0] exp);
        check("target_valid", target_valid, 1'b1);
        check("target", branch_target, exp);
    endtask
    task automatic sfr_wr(input logic [7:0] ad, dat);
        @(posedge core_clk);
        sfr_addr <= ad;
        sfr_wdata <= dat;
        sfr_write <= 1'b1;
        @(posedge core_clk);
        sfr_write <= 1'b0;
    endtask
    task automatic sfr_rd(input logic [7:0] ad, exp);
        @(posedge core_clk);
        sfr_addr <= ad;
        sfr_read <= 1'b1;
        @(posedge core_clk);
        sfr_read <= 1'b0;
        @(negedge core_clk);
        check("sfr_rdata", sfr_rdata, exp);
    endtask
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        @(negedge core_clk);
        check("reset busy", busy, 1'b0);
        sfr_rd(8'h82, 8'h00);
        sfr_rd(8'h83, 8'h00);
        sfr_wr(8'h82, 8'h34);
        sfr_wr(8'h83, 8'h12);
        sfr_rd(8'h82, 8'h34);
        sfr_rd(8'h83, 8'h12);
        check("pointer", data_pointer, 16'h1234);
        sfr_rd(8'h81, 8'h00);
        @(posedge core_clk);
        clk_en <= 1'b0;
        sfr_wr(8'h82, 8'h55);
        @(posedge core_clk);
        clk_en <= 1'b1;
        sfr_rd(8'h82, 8'h34);
        run('{8'he4, 8'h23, 8'h03, 8'h33, 8'h13, 8'hc4, 8'he8, 8'hf8,
            8'hc8, 8'hc3, 8'hd3, 8'hb3, 8'h00, 8'ha5}, 0, 1, 1);
        run('{8'hf4, 8'he6, 8'hf7, 8'hc6, 8'hd6}, 0, 1, 2);
        run('{8'he5, 8'h74, 8'hc0, 8'hd0, 8'hc5, 8'hc2, 8'hd2, 8'hb2,
            8'h82, 8'ha2, 8'h92}, 0, 2, 2);
        run('{8'h85, 8'h75, 8'h90}, 0, 3, 3);
        run('{8'h83, 8'he2, 8'hf2, 8'he0, 8'hf0}, 0, 1, 3);
        run('{8'h40, 8'h50, 8'h60, 8'h70, 8'hd8}, 0, 2, 2);
        run('{8'h20, 8'h30, 8'h10, 8'hb4, 8'hb8, 8'hd5}, 0, 3, 3);
        run('{8'hb5, 8'hb6}, 0, 3, 4);
        run('{8'h40, 8'h60, 8'hd8, 8'h80, 8'h01, 8'h11}, 1, 2, 4);
        run('{8'h20, 8'hb8, 8'hd5, 8'h02, 8'h12}, 1, 3, 5);
        run('{8'hb5, 8'hb4, 8'hb6}, 1, 3, 6);
        run('{8'h73}, 1, 1, 3);
        run('{8'h22, 8'h32}, 1, 1, 6);
        run('{8'h93}, 1, 1, 4);
        dec(16'h1000, 8'h80, 8'hfe, 8'h00, 1, 2, 4);
        tgt(16'h1000);
        dec(16'h2000, 8'h40, 8'h10, 8'h00, 1, 2, 4);
        tgt(16'h2012);
        dec(16'h3000, 8'h20, 8'h00, 8'h80, 1, 3, 5);
        tgt(16'h2f83);
        dec(16'h47fe, 8'he1, 8'h23, 8'h00, 1, 2, 4);
        tgt(16'h4f23);
        dec(16'h0100, 8'h12, 8'hab, 8'hcd, 1, 3, 5);
        tgt(16'habcd);
        for (int b = 0; b < 4; b++) begin
            @(posedge core_clk);
            bank_select <= b[1:0];
            dec(16'h0100, 8'hed, 8'h00, 8'h00, 0, 1, 1);
            check("bank", bank_reg_addr, {3'h0, b[1:0], 3'h5});
            dec(16'h0100, 8'he7, 8'h00, 8'h00, 0, 1, 2);
            check("ind", indirect_reg_addr, {3'h0, b[1:0], 3'h1});
        end
        dec(16'h0100, 8'he5, 8'h7f, 8'h00, 0, 2, 2);
        check("sfr space", direct_is_sfr, 1'b0);
        check("no target", target_valid, 1'b0);
        dec(16'h0100, 8'he5, 8'h80, 8'h00, 0, 2, 2);
        check("sfr space", direct_is_sfr, 1'b1);
        dec(16'h0100, 8'ha5, 8'h00, 8'h00, 0, 1, 1);
        check("nop_like", nop_like, 1'b1);
        @(posedge core_clk);
        flash_read_timing <= 2'h1;
        dec(16'h0101, 8'h02, 8'h00, 8'h00, 1, 3, 7);
        dec(16'h0101, 8'h02, 8'h00, 8'h00, 1, 3, 7);
        dec(16'h0100, 8'h02, 8'h00, 8'h00, 1, 3, 6);
        dec(16'h0101, 8'h40, 8'h00, 8'h00, 0, 2, 2);
        @(posedge core_clk);
        flash_read_timing <= 2'h2;
        dec(16'h0101, 8'h93, 8'h00, 8'h00, 1, 1, 7);
        dec(16'h0100, 8'h93, 8'h00, 8'h00, 1, 1, 6);
        report_and_stop;
    end
    initial begin
        #2000000;
        n_mismatch++;
        report_and_stop;
    end
endmodule // test_instruction_timing_decoder
